// [rtl/brc_map.svh]
// offsets, field positions, reset values and counts of the bus release block
`ifndef BRC_MAP_SVH
`define BRC_MAP_SVH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define BRC_OFF_REG       12'h000
`define BRC_APB_AW        12

// ----------------------------------------------------------------------------
// field layout
// ----------------------------------------------------------------------------
`define BRC_BIT_A23       7
`define BRC_BIT_ALLOW     0
`define BRC_PINS          4
`define BRC_RSVD_MASK     8'h0e
`define BRC_WMASK_WIDE    8'hf1
`define BRC_WMASK_NARROW  8'h01

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define BRC_INIT_NARROW   8'hfe
`define BRC_INIT_WIDE     8'hee
`define BRC_RST_TMP       8'hfe
`define BRC_SYNC_RST      5'h10

// ----------------------------------------------------------------------------
// modes and counts
// ----------------------------------------------------------------------------
`define BRC_MODE_3        3'h3
`define BRC_MODE_4        3'h4
`define BRC_INIT_WAIT     3'h4
`define BRC_INIT_INC      3'h1

`endif

// [rtl/brc_pkg.sv]
// types shared by the bus release and address pin control block
package brc_pkg;

    typedef logic [2:0] brc_mode_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } brc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } brc_apb_rsp_t;

    typedef enum logic {
        BRC_HO_IDLE,
        BRC_HO_GRANT
    } brc_ho_state_t;

endpackage

// [rtl/brc_sync.sv]
// three-stage synchroniser, a bit changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module brc_sync #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] out_r;
    logic [W-1:0] out_nxt;

    assign out_nxt = (~(s2_r ^ s3_r) & s2_r) | ((s2_r ^ s3_r) & out_r);
    assign dout    = out_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_r  <= RST;
            s2_r  <= RST;
            s3_r  <= RST;
            out_r <= RST;
        end
        else
        begin
            s1_r  <= din;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            out_r <= out_nxt;
        end
    end

endmodule // brc_sync

`default_nettype wire

// [rtl/brc_handover.sv]
// grants the external bus to an outside master when allowed
`timescale 1ns/1ps
`default_nettype none

module brc_handover (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic allow,
    input  wire logic req_n,
    input  wire logic bus_idle,
    output logic      ack_n,
    output logic      ack_oe,
    output logic      released
);
    import brc_pkg::*;

    brc_ho_state_t state_r;
    brc_ho_state_t state_nxt;
    logic          ack_n_r;
    logic          ack_oe_r;
    logic          rel_r;
    wire           grant_nxt;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            BRC_HO_IDLE:
            begin
                if (allow && !req_n && bus_idle)
                    state_nxt = BRC_HO_GRANT;
            end
            BRC_HO_GRANT:
            begin
                if (req_n)
                    state_nxt = BRC_HO_IDLE;
            end
            default:
                state_nxt = BRC_HO_IDLE;
        endcase
    end

    assign grant_nxt = (state_nxt == BRC_HO_GRANT);
    assign ack_n     = ack_n_r;
    assign ack_oe    = ack_oe_r;
    assign released  = rel_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r  <= BRC_HO_IDLE;
            ack_n_r  <= 1'b1;
            ack_oe_r <= 1'b0;
            rel_r    <= 1'b0;
        end
        else
        begin
            state_r  <= state_nxt;
            ack_n_r  <= ~grant_nxt;
            // pin stays a port pin unless handover is allowed or the bus is granted
            ack_oe_r <= allow | grant_nxt;
            rel_r    <= grant_nxt;
        end
    end

endmodule // brc_handover

`default_nettype wire

// [rtl/brc_ctrl.sv]
// bus release and address pin control register with apb slave
`timescale 1ns/1ps
`default_nettype none
`include "brc_map.svh"

module brc_ctrl (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire brc_pkg::brc_apb_req_t apb_req,
    output brc_pkg::brc_apb_rsp_t      apb_rsp,
    input  wire brc_pkg::brc_mode_t    op_mode_pin,
    input  wire logic                  hw_standby_pin,
    input  wire logic [3:0]            addr_hi,
    input  wire logic [3:0]            port_dout,
    input  wire logic [3:0]            port_oe,
    output logic [3:0]                 porta_pin_out,
    output logic [3:0]                 porta_pin_oe,
    output logic [3:0]                 porta_addr_sel,
    input  wire logic                  ext_bus_request_pin_n,
    input  wire logic                  bus_idle,
    output logic                       ext_bus_ack_n,
    output logic                       ext_bus_ack_oe,
    output logic                       bus_released,
    output logic                       bus_handover_allow
);
    import brc_pkg::*;

    // ------------------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------------------
    function automatic logic is_wide(input brc_mode_t m);
        is_wide = (m == `BRC_MODE_3) || (m == `BRC_MODE_4);
    endfunction

    function automatic logic [7:0] init_val(input brc_mode_t m);
        init_val = is_wide(m) ? `BRC_INIT_WIDE : `BRC_INIT_NARROW;
    endfunction

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    logic [4:0] sync_in;
    logic [4:0] sync_out;
    brc_mode_t  mode_s;
    logic       hwstby_s;
    logic       req_n_s;

    assign sync_in = {ext_bus_request_pin_n, hw_standby_pin, op_mode_pin};

    brc_sync #(
        .W   (5),
        .RST (`BRC_SYNC_RST)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (sync_in),
        .dout    (sync_out)
    );

    assign mode_s   = sync_out[2:0];
    assign hwstby_s = sync_out[3];
    assign req_n_s  = sync_out[4];

    wire wide = is_wide(mode_s);

    // ------------------------------------------------------------------------
    // initial load after reset release and during hardware standby
    // ------------------------------------------------------------------------
    logic [2:0] init_cnt_r;
    logic       init_done_r;
    wire        init_hit  = (init_cnt_r == `BRC_INIT_WAIT);
    wire        init_load = (~init_done_r & init_hit) | hwstby_s;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            init_cnt_r  <= 3'h0;
            init_done_r <= 1'b0;
        end
        else if (!init_done_r)
        begin
            init_cnt_r  <= init_cnt_r + `BRC_INIT_INC;
            init_done_r <= init_hit;
        end
    end

    // ------------------------------------------------------------------------
    // apb slave, one setup and one access cycle per transfer
    // ------------------------------------------------------------------------
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] prdata_r;
    logic [7:0]  reg_r;
    logic [7:0]  reg_nxt;

    wire        setup_ph = apb_req.psel & ~apb_req.penable;
    wire        acc_ph   = apb_req.psel & apb_req.penable & pready_r;
    wire        addr_hit = (apb_req.paddr == `BRC_OFF_REG);
    wire        wr_en    = acc_ph & apb_req.pwrite & addr_hit;
    wire [7:0]  wmask    = wide ? `BRC_WMASK_WIDE : `BRC_WMASK_NARROW;
    wire [7:0]  wr_val   = (reg_r & ~wmask) | (apb_req.pwdata[7:0] & wmask);
    wire [31:0] rd_val   = {24'h000000, reg_r | `BRC_RSVD_MASK};
    wire        rd_take  = setup_ph & ~apb_req.pwrite & addr_hit;
    wire [31:0] prdata_nxt = rd_take ? rd_val : 32'h00000000;

    // load wins over a write landing in the same cycle
    assign reg_nxt = init_load ? init_val(mode_s) :
                     wr_en     ? wr_val : reg_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end
        else
        begin
            pready_r  <= setup_ph;
            pslverr_r <= setup_ph & ~addr_hit;
            prdata_r  <= prdata_nxt;
        end
    end

    // holds across software standby, only loads and writes change it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            reg_r <= `BRC_RST_TMP;
        else
            reg_r <= reg_nxt;
    end

    assign apb_rsp.prdata  = prdata_r;
    assign apb_rsp.pready  = pready_r;
    assign apb_rsp.pslverr = pslverr_r;

    // ------------------------------------------------------------------------
    // port a pin function, pin 4+i carries address bit 23-i
    // ------------------------------------------------------------------------
    logic [3:0] sel_nxt;
    logic [3:0] pout_nxt;
    logic [3:0] poe_nxt;
    logic [3:0] sel_r;
    logic [3:0] pout_r;
    logic [3:0] poe_r;

    genvar i;
    generate
        for (i = 0; i < `BRC_PINS; i++)
        begin : g_pin
            assign sel_nxt[i]  = wide & ~reg_r[`BRC_BIT_A23 - i];
            assign pout_nxt[i] = sel_nxt[i] ? addr_hi[`BRC_PINS - 1 - i]
                                            : port_dout[i];
            assign poe_nxt[i]  = sel_nxt[i] | port_oe[i];
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sel_r  <= 4'h0;
            pout_r <= 4'h0;
            poe_r  <= 4'h0;
        end
        else
        begin
            sel_r  <= sel_nxt;
            pout_r <= pout_nxt;
            poe_r  <= poe_nxt;
        end
    end

    assign porta_addr_sel = sel_r;
    assign porta_pin_out  = pout_r;
    assign porta_pin_oe   = poe_r;

    // ------------------------------------------------------------------------
    // bus handover
    // ------------------------------------------------------------------------
    logic allow_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            allow_r <= 1'b0;
        else
            allow_r <= reg_r[`BRC_BIT_ALLOW];
    end

    assign bus_handover_allow = allow_r;

    brc_handover u_handover (
        .pclk     (pclk),
        .presetn  (presetn),
        .allow    (allow_r),
        .req_n    (req_n_s),
        .bus_idle (bus_idle),
        .ack_n    (ext_bus_ack_n),
        .ack_oe   (ext_bus_ack_oe),
        .released (bus_released)
    );

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    property p_init_wide;
        @(posedge pclk) disable iff (!presetn)
        (init_load && wide) |=> (reg_r == `BRC_INIT_WIDE);
    endproperty
    a_init_wide: assert property (p_init_wide)
        else $error("wide mode load value wrong");

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        (!init_load && !wr_en) |=> $stable(reg_r);
    endproperty
    a_hold: assert property (p_hold)
        else $error("register changed without load or write");

    property p_a23_sel;
        @(posedge pclk) disable iff (!presetn)
        (wide && !reg_r[`BRC_BIT_A23]) |=> sel_r[0];
    endproperty
    a_a23_sel: assert property (p_a23_sel)
        else $error("pin 4 not switched to address");

    property p_a22_port;
        @(posedge pclk) disable iff (!presetn)
        reg_r[`BRC_BIT_A23 - 1] |=> !sel_r[1];
    endproperty
    a_a22_port: assert property (p_a22_port)
        else $error("pin 5 carries address while bit set");

    property p_a21_data;
        @(posedge pclk) disable iff (!presetn)
        sel_nxt[2] |=> (pout_r[2] == $past(addr_hi[1])) && poe_r[2];
    endproperty
    a_a21_data: assert property (p_a21_data)
        else $error("pin 6 does not drive address bit 21");

    property p_narrow_ro;
        @(posedge pclk) disable iff (!presetn)
        (!wide && wr_en && !init_load) |=> $stable(reg_r[7:4]);
    endproperty
    a_narrow_ro: assert property (p_narrow_ro)
        else $error("address enable bits written in narrow mode");

    property p_a20_init;
        @(posedge pclk) disable iff (!presetn)
        (init_load && wide) ##1 wide |=> sel_r[3];
    endproperty
    a_a20_init: assert property (p_a20_init)
        else $error("pin 7 not address after wide load");

    property p_narrow_pin;
        @(posedge pclk) disable iff (!presetn)
        !wide |=> (sel_r == 4'h0);
    endproperty
    a_narrow_pin: assert property (p_narrow_pin)
        else $error("address pin selected in narrow mode");

    property p_rsvd_read;
        @(posedge pclk) disable iff (!presetn)
        rd_take |=> (prdata_r[3:1] == 3'h7) && (prdata_r[31:8] == 24'h0);
    endproperty
    a_rsvd_read: assert property (p_rsvd_read)
        else $error("reserved bits read wrong");

    property p_refuse;
        @(posedge pclk) disable iff (!presetn)
        (!allow_r && ext_bus_ack_n) |=> ext_bus_ack_n;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("bus handed over while not allowed");

    property p_grant;
        @(posedge pclk) disable iff (!presetn)
        (allow_r && !req_n_s && bus_idle && ext_bus_ack_n) |=> !ext_bus_ack_n;
    endproperty
    a_grant: assert property (p_grant)
        else $error("allowed request not granted");

    property p_wr_effect;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && !init_load) |=> (reg_r[0] == $past(apb_req.pwdata[0]))
            ##1 (allow_r == $past(reg_r[0]));
    endproperty
    a_wr_effect: assert property (p_wr_effect)
        else $error("written allow bit not in effect next cycle");

endmodule // brc_ctrl

`default_nettype wire

// [tb/brc_ext_master.sv]
// outside bus master model that asks for the external bus
`timescale 1ns/1ps
`default_nettype none

module brc_ext_master (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic want,
    input  wire logic ack_n,
    input  wire logic ack_oe,
    output logic      req_n
);
    // the ack pin has a pull-up, so an undriven pin reads high
    wire logic       ack_wire = ack_oe ? ack_n : 1'b1;
    logic      [3:0] hold_r;

    // request is held until acknowledged, then the bus is used 8 cycles
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            req_n  <= 1'b1;
            hold_r <= 4'h0;
        end
        else
        begin
            hold_r <= ack_wire ? 4'h0 : hold_r + ((hold_r != 4'hf) ? 4'h1 : 4'h0);
            req_n  <= !(want && hold_r < 4'h8);
        end
    end
endmodule // brc_ext_master

`default_nettype wire

// [tb/bus_release_addr_pin_ctrl_tb.sv]
// self-checking testbench of the bus release and address pin block
`timescale 1ns/1ps
`default_nettype none

module bus_release_addr_pin_ctrl_tb;
    import brc_pkg::*;
    logic         pclk = 1'b0;
    logic         presetn = 1'b0;
    brc_apb_req_t req = '0;
    brc_apb_rsp_t rsp;
    brc_mode_t    mode = 3'h1;
    logic         hws = 1'b0, want = 1'b0, idle = 1'b1, req_n;
    logic [3:0]   ahi = 4'h0, pdo = 4'h0, poe = 4'h0, pout, pins_oe, sel;
    logic         ack_n, ack_oe, rel, allow, wide;
    logic [7:0]   shadow;
    logic [32:0]  exp_q[$];
    logic [32:0]  ent;
    int           error_cnt = 0, checked = 0, cyc = 0;
    integer       seed = 32'h503f;

    always #5 pclk = ~pclk;

    brc_ctrl i_brc_ctrl (.pclk(pclk), .presetn(presetn), .apb_req(req),
        .apb_rsp(rsp), .op_mode_pin(mode), .hw_standby_pin(hws),
        .addr_hi(ahi), .port_dout(pdo), .port_oe(poe), .porta_pin_out(pout),
        .porta_pin_oe(pins_oe), .porta_addr_sel(sel),
        .ext_bus_request_pin_n(req_n), .bus_idle(idle), .ext_bus_ack_n(ack_n),
        .ext_bus_ack_oe(ack_oe), .bus_released(rel),
        .bus_handover_allow(allow));

    brc_ext_master i_brc_ext_master (.pclk(pclk), .presetn(presetn),
        .want(want), .ack_n(ack_n), .ack_oe(ack_oe), .req_n(req_n));

    task automatic chk(input string nm, input logic [31:0] got, exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // response watcher
    // ------------------------------------------------------------------
    always @(posedge pclk)
        if (req.psel && req.penable && rsp.pready === 1'b1 && exp_q.size() > 0)
        begin
            ent = exp_q.pop_front();
            chk("pslverr", {31'h0, rsp.pslverr}, {31'h0, ent[32]});
            if (!req.pwrite)
                chk("prdata", rsp.prdata, ent[31:0]);
        end

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            finish_test();
        end
    end

    // ------------------------------------------------------------------
    // bus master and checks
    // ------------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        exp_q.push_back({a != 12'h000,
                         (wr || a != 12'h000) ? 32'h0 : {24'h0, shadow}});
        @(posedge pclk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge pclk);
        req.penable <= 1'b1;
        // hold the access until pready, only the bench timeout ends it
        do
        begin
            @(posedge pclk);
        end
        while (rsp.pready !== 1'b1);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (wr && a == 12'h000)
            shadow = wide ? ((shadow & 8'h0e) | (d[7:0] & 8'hf1))
                          : ((shadow & 8'hfe) | (d[7:0] & 8'h01));
    endtask

    task automatic pins();
        logic [3:0] es, eo, ee;
        ahi <= 4'($random(seed));
        pdo <= 4'($random(seed));
        poe <= 4'($random(seed));
        repeat (3) @(posedge pclk);
        for (int i = 0; i < 4; i++)
        begin
            es[i] = wide & ~shadow[7-i];
            eo[i] = es[i] ? ahi[3-i] : pdo[i];
            ee[i] = es[i] | poe[i];
        end
        chk("addr_sel", {28'h0, sel}, {28'h0, es});
        chk("pin_out", {28'h0, pout}, {28'h0, eo});
        chk("pin_oe", {28'h0, pins_oe}, {28'h0, ee});
        chk("allow", {31'h0, allow}, {31'h0, shadow[0]});
        chk("ack_oe", {31'h0, ack_oe}, {31'h0, shadow[0]});
    endtask

    task automatic ho();
        int n;
        // a busy internal bus holds the grant off while the request is asserted
        idle <= 1'b0;
        want <= 1'b1;
        repeat (12) @(posedge pclk);
        chk("busy_hold", {31'h0, rel}, 32'h0);
        idle <= 1'b1;
        n = 0;
        while (rel !== 1'b1 && n < 30)
        begin
            @(posedge pclk);
            n++;
        end
        chk("released", {31'h0, rel}, {31'h0, shadow[0]});
        chk("ack_n", {31'h0, ack_n}, {31'h0, ~shadow[0]});
        want <= 1'b0;
        repeat (30) @(posedge pclk);
        chk("released_end", {31'h0, rel}, 32'h0);
    endtask

    // ------------------------------------------------------------------
    // main sequence, once for each of operating modes 1 to 4
    // ------------------------------------------------------------------
    initial
    begin
        for (int m = 1; m <= 4; m++)
        begin
            mode <= brc_mode_t'(m);
            presetn <= 1'b0;
            repeat (16) @(posedge pclk);
            presetn <= 1'b1;
            repeat (10) @(posedge pclk);
            wide = (m >= 3);
            shadow = wide ? 8'hee : 8'hfe;
            apb(1'b0, 12'h000, 32'h0);
            pins();
            ho();
            apb(1'b1, 12'h000, $random(seed));
            apb(1'b0, 12'h000, 32'h0);
            pins();
            apb(1'b1, 12'h000, 32'h0000_0001);
            apb(1'b0, 12'h000, 32'h0);
            pins();
            ho();
            apb(1'b1, 12'h004, 32'h0000_00f0);
            apb(1'b0, 12'h004, 32'h0);
            apb(1'b0, 12'h000, 32'h0);
            hws <= 1'b1;
            repeat (8) @(posedge pclk);
            hws <= 1'b0;
            repeat (12) @(posedge pclk);
            shadow = wide ? 8'hee : 8'hfe;
            apb(1'b0, 12'h000, 32'h0);
            pins();
            // leave a changed value for the next reset to clear
            apb(1'b1, 12'h000, 32'h0000_0001);
            $display("test in mode %0d finished", m);
        end
        repeat (4) @(posedge pclk);
        finish_test();
    end
endmodule // bus_release_addr_pin_ctrl_tb

`default_nettype wire
